/* rtl/ubf_pkg.sv */
package ubf_pkg;

  // Register address and grant count widths
  localparam int ADDR_W = 4;
  localparam int GRANT_W = 16;

  // Register word addresses
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CWK = 4'h1;
  localparam logic [ADDR_W-1:0] REG_PARITY = 4'h2;
  localparam logic [ADDR_W-1:0] REG_GUARD = 4'h3;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;

  // Control fields
  localparam int CTRL_FEC_BIT = 0;
  localparam int CTRL_SHORT_BIT = 1;
  localparam int CTRL_ABORT_BIT = 2;

  // Status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_OVERRUN_BIT = 1;
  localparam int STAT_COUNT_LSB = 16;

  // Smallest information field of any codeword
  localparam logic [7:0] MIN_INFO = 8'h10;

  // Reset values
  localparam logic CTRL_FEC_RST = 1'b1;
  localparam logic CTRL_SHORT_RST = 1'b0;
  localparam logic [7:0] CWK_RST = 8'h10;
  localparam logic [7:0] PARITY_RST = 8'h04;
  localparam logic [7:0] GUARD_RST = 8'h02;

  // What an output byte is
  typedef enum logic [1:0] {
    KIND_DATA,
    KIND_ZERO,
    KIND_PARITY,
    KIND_RAW
  } ubf_kind_t;

  // Burst byte from the MAC side
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } ubf_pkt_t;

  // Byte handed to the scrambler
  typedef struct packed {
    logic [7:0] data;
    ubf_kind_t kind;
    logic cw_first;
    logic cw_last;
  } ubf_out_t;

endpackage

/* rtl/ubf_framer.sv */
// Functional notes
// - Every FEC codeword carries sixteen or more bytes
// - Contention and scheduled grants framed alike
// - Fixed mode zero-pads last data codeword
// - Fixed mode adds zero codewords while they fit
// - Shortened mode uses full codewords for data
// - Shortened final codeword never below sixteen bytes
// - Shortened mode adds full zero codewords while they fit
// - Then one shortened zero codeword if it fits
// - Under sixteen bytes left: no shortened codeword
// - Fixed stage order, framer feeds the scrambler
`timescale 1ns/100ps
module ubf_framer import ubf_pkg::*; (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_grant_valid,
  input wire logic [GRANT_W-1:0] i_grant_bytes,
  output logic o_grant_ready,
  input wire logic i_pkt_valid,
  input wire ubf_pkt_t i_pkt,
  output logic o_pkt_ready,
  output logic o_out_valid,
  output ubf_out_t o_out,
  input wire logic i_out_ready,
  output logic o_burst_done
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_NEXT,
    ST_DATA,
    ST_ZPAD,
    ST_PARITY,
    ST_DRAIN,
    ST_DONE
  } ubf_state_t;

  ubf_state_t st_q;
  logic fec_q;
  logic short_q;
  logic [7:0] cwk_q;
  logic [7:0] par_q;
  logic [7:0] guard_q;
  logic overrun_q;
  logic [15:0] bursts_q;
  logic [31:0] rdata_q;
  logic [GRANT_W-1:0] rem_q;
  logic [7:0] cnt_q;
  logic [7:0] len_q;
  logic data_end_q;
  logic out_valid_q;
  ubf_out_t out_q;

  logic abort;
  logic adv;
  logic emit;
  logic take;
  logic [GRANT_W-1:0] need_full;
  logic [GRANT_W-1:0] need_short;
  logic full_fits;
  logic short_fits;
  logic overrun_set;
  logic [7:0] cnt_inc;
  logic [GRANT_W-1:0] short_len;

  // Write strobes and derived fit tests
  assign abort = i_wr && (i_addr == REG_CTRL) && i_wdata[CTRL_ABORT_BIT];
  assign adv = !out_valid_q || i_out_ready;
  assign take = adv && i_pkt_valid && (st_q == ST_DATA);
  assign emit = take || (adv && (st_q == ST_ZPAD)) || (adv && (st_q == ST_PARITY) && (par_q != 8'h00));
  assign cnt_inc = cnt_q + 8'h01;
  assign need_full = {8'h00, cwk_q} + {8'h00, par_q};
  assign need_short = {8'h00, MIN_INFO} + {8'h00, par_q};
  assign full_fits = rem_q >= need_full;
  assign short_fits = short_q && (rem_q >= need_short);
  assign short_len = rem_q - {8'h00, par_q};
  assign overrun_set = (st_q == ST_NEXT) && !data_end_q && !full_fits && !short_fits;

  // Handshakes toward the MAC and grant scheduler
  assign o_pkt_ready = (adv && (st_q == ST_DATA)) || (st_q == ST_DRAIN);
  assign o_grant_ready = (st_q == ST_IDLE);
  assign o_burst_done = (st_q == ST_DONE);
  assign o_out_valid = out_valid_q;
  assign o_out = out_q;
  assign o_rdata = rdata_q;

  // Configuration registers; a short k is raised to the floor
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fec_q <= CTRL_FEC_RST;
      short_q <= CTRL_SHORT_RST;
      cwk_q <= CWK_RST;
      par_q <= PARITY_RST;
      guard_q <= GUARD_RST;
    end else if (i_wr) begin
      case (i_addr)
        REG_CTRL: begin
          fec_q <= i_wdata[CTRL_FEC_BIT];
          short_q <= i_wdata[CTRL_SHORT_BIT];
        end
        REG_CWK: begin
          cwk_q <= (i_wdata[7:0] < MIN_INFO) ? MIN_INFO : i_wdata[7:0];
        end
        REG_PARITY: begin
          par_q <= i_wdata[7:0];
        end
        REG_GUARD: begin
          guard_q <= i_wdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Status: overrun is sticky, write one to clear, a new event wins
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      overrun_q <= 1'b0;
      bursts_q <= 16'h0000;
    end else begin
      if (overrun_set) begin
        overrun_q <= 1'b1;
      end else if (i_wr && (i_addr == REG_STATUS) && i_wdata[STAT_OVERRUN_BIT]) begin
        overrun_q <= 1'b0;
      end
      if (st_q == ST_DONE) begin
        bursts_q <= bursts_q + 16'h0001;
      end
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        REG_CTRL: rdata_q <= {30'h0000_0000, short_q, fec_q};
        REG_CWK: rdata_q <= {24'h00_0000, cwk_q};
        REG_PARITY: rdata_q <= {24'h00_0000, par_q};
        REG_GUARD: rdata_q <= {24'h00_0000, guard_q};
        REG_STATUS: rdata_q <= {bursts_q, 14'h0000, overrun_q, (st_q != ST_IDLE)};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // Framing sequencer. The grant carries no region type, so contention
  // and scheduled grants go through one path.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= ST_IDLE;
      rem_q <= '0;
      cnt_q <= 8'h00;
      len_q <= 8'h00;
      data_end_q <= 1'b0;
    end else if (abort) begin
      st_q <= ST_IDLE;
      data_end_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (i_grant_valid) begin
            // Guard time is reserved once, up front
            rem_q <= (i_grant_bytes > {8'h00, guard_q}) ? i_grant_bytes - {8'h00, guard_q} : '0;
            data_end_q <= 1'b0;
            cnt_q <= 8'h00;
            st_q <= fec_q ? ST_NEXT : ST_DATA;
          end
        end
        ST_NEXT: begin
          cnt_q <= 8'h00;
          if (full_fits) begin
            len_q <= cwk_q;
            st_q <= data_end_q ? ST_ZPAD : ST_DATA;
          end else if (short_fits) begin
            len_q <= short_len[7:0];
            st_q <= data_end_q ? ST_ZPAD : ST_DATA;
          end else begin
            // Too little room left: stop, or drop the rest of the packet
            st_q <= data_end_q ? ST_DONE : ST_DRAIN;
          end
        end
        ST_DATA: begin
          if (take) begin
            if (!fec_q) begin
              if (i_pkt.last) begin
                st_q <= ST_DONE;
              end
            end else begin
              cnt_q <= cnt_inc;
              rem_q <= rem_q - 16'h0001;
              if (i_pkt.last) begin
                data_end_q <= 1'b1;
              end
              if (cnt_inc == len_q) begin
                cnt_q <= 8'h00;
                st_q <= ST_PARITY;
              end else if (i_pkt.last && short_q) begin
                // Final block shrinks, never under the floor
                len_q <= (cnt_inc < MIN_INFO) ? MIN_INFO : cnt_inc;
                if (cnt_inc >= MIN_INFO) begin
                  cnt_q <= 8'h00;
                  st_q <= ST_PARITY;
                end
                if (cnt_inc < MIN_INFO) begin
                  st_q <= ST_ZPAD;
                end
              end else if (i_pkt.last) begin
                st_q <= ST_ZPAD;
              end
            end
          end
        end
        ST_ZPAD: begin
          if (adv) begin
            cnt_q <= cnt_inc;
            rem_q <= rem_q - 16'h0001;
            if (cnt_inc == len_q) begin
              cnt_q <= 8'h00;
              st_q <= ST_PARITY;
            end
          end
        end
        ST_PARITY: begin
          if (par_q == 8'h00) begin
            st_q <= ST_NEXT;
          end else if (adv) begin
            cnt_q <= cnt_inc;
            rem_q <= rem_q - 16'h0001;
            if (cnt_inc == par_q) begin
              st_q <= ST_NEXT;
            end
          end
        end
        ST_DRAIN: begin
          if (i_pkt_valid && i_pkt.last) begin
            st_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Output byte register. Parity bytes are slots, zero-valued, for the
  // Reed-Solomon core ahead of the scrambler to overwrite.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_valid_q <= 1'b0;
      out_q <= '0;
    end else if (abort) begin
      out_valid_q <= 1'b0;
    end else if (emit) begin
      out_valid_q <= 1'b1;
      out_q.data <= (st_q == ST_DATA) ? i_pkt.data : 8'h00;
      out_q.cw_first <= fec_q && (st_q != ST_PARITY) && (cnt_q == 8'h00);
      out_q.cw_last <= (st_q == ST_PARITY) && (cnt_inc == par_q);
      case (st_q)
        ST_DATA: out_q.kind <= fec_q ? KIND_DATA : KIND_RAW;
        ST_ZPAD: out_q.kind <= KIND_ZERO;
        default: out_q.kind <= KIND_PARITY;
      endcase
    end else if (i_out_ready) begin
      out_valid_q <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_cw_open;
    (st_q == ST_NEXT) && (full_fits || short_fits);
  endsequence

  sequence s_info_done;
    (st_q == ST_DATA || st_q == ST_ZPAD) && emit && (cnt_inc == len_q);
  endsequence

  a_cw_min_len: assert property (s_cw_open |=> len_q >= MIN_INFO)
    else $error("codeword opened below the minimum size");

  a_grant_uniform: assert property ((st_q == ST_IDLE) && i_grant_valid && !abort |=>
    st_q == (fec_q ? ST_NEXT : ST_DATA))
    else $error("grant not taken into framing");

  a_fixed_pad: assert property (fec_q && !short_q && take && i_pkt.last && (cnt_inc != len_q) && !abort |=>
    st_q == ST_ZPAD && len_q == cwk_q)
    else $error("fixed mode did not pad the last codeword");

  a_zero_fill: assert property (emit && (st_q == ST_ZPAD) && !abort |=>
    out_q.data == 8'h00 && out_q.kind == KIND_ZERO)
    else $error("fill byte not zero");

  a_full_first: assert property (s_cw_open and (full_fits && !abort) |=> len_q == cwk_q)
    else $error("full codeword not chosen while it fits");

  a_short_floor: assert property (fec_q && short_q && (st_q == ST_PARITY) && (cnt_q == 8'h00)
    |-> len_q >= MIN_INFO)
    else $error("shortened codeword below floor");

  a_fill_fits: assert property (s_cw_open and !abort |=>
    rem_q >= {8'h00, len_q} + {8'h00, par_q})
    else $error("codeword overruns the grant");

  a_short_zero: assert property (s_cw_open and (!full_fits && data_end_q && !abort) |=>
    st_q == ST_ZPAD && len_q == $past(short_len[7:0]))
    else $error("shortened zero codeword missing");

  a_no_short: assert property ((st_q == ST_NEXT) && data_end_q && !full_fits && !short_fits && !abort
    |=> st_q == ST_DONE ##1 st_q == ST_IDLE)
    else $error("codeword placed without room");

  a_parity_next: assert property (s_info_done and (fec_q && !abort) |=> st_q == ST_PARITY)
    else $error("parity not after information block");

  a_parity_len: assert property ((st_q == ST_PARITY) && emit && (cnt_inc == par_q) && !abort
    |=> out_q.cw_last ##1 (st_q != ST_PARITY))
    else $error("parity run length wrong");

  a_nofec_raw: assert property (!fec_q |-> st_q != ST_ZPAD && st_q != ST_PARITY)
    else $error("codeword framing while FEC off");

  a_abort_idle: assert property (abort |=> st_q == ST_IDLE && !out_valid_q)
    else $error("abort did not return to idle");

endmodule

/* tb/ubf_mac_model.sv */
`timescale 1ns/100ps
// Stands in for the MAC side: one grant per burst, then the burst bytes
module ubf_mac_model import ubf_pkg::*; (
  input wire logic i_clk,
  input wire logic i_grant_ready,
  input wire logic i_pkt_ready,
  input wire logic i_slow,
  output logic o_grant_valid,
  output logic [GRANT_W-1:0] o_grant_bytes,
  output logic o_pkt_valid,
  output ubf_pkt_t o_pkt
);
  // Quiet lines at time zero
  initial begin
    o_grant_valid = 1'b0;
    o_grant_bytes = '0;
    o_pkt_valid = 1'b0;
    o_pkt = '0;
  end

  // Caller sizes the grant so a shortened tail keeps sixteen bytes
  // Released lines show the inverse of the last value, so nothing stale can match
  task automatic burst(input logic [GRANT_W-1:0] g, input logic [7:0] d[$]);
    o_grant_valid <= 1'b1;
    o_grant_bytes <= g;
    do @(posedge i_clk); while (i_grant_ready !== 1'b1);
    o_grant_valid <= 1'b0;
    o_grant_bytes <= ~g;
    foreach (d[i]) begin
      if (i_slow && i[0]) begin
        o_pkt_valid <= 1'b0;
        o_pkt <= ~o_pkt;
        @(posedge i_clk);
      end
      o_pkt_valid <= 1'b1;
      o_pkt <= '{d[i], i == d.size() - 1};
      do @(posedge i_clk); while (i_pkt_ready !== 1'b1);
    end
    o_pkt_valid <= 1'b0;
    o_pkt <= ~o_pkt;
  endtask
endmodule

/* tb/test_ubf_framer.sv */
`timescale 1ns/100ps
module test_ubf_framer import ubf_pkg::*; ;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [31:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_out_ready = 1'b1;
  logic slow = 1'b0;
  logic [31:0] o_rdata;
  logic i_grant_valid, o_grant_ready, i_pkt_valid, o_pkt_ready, o_out_valid, o_burst_done;
  logic [GRANT_W-1:0] i_grant_bytes;
  ubf_pkt_t i_pkt;
  ubf_out_t o_out;
  ubf_out_t exp_q[$];
  logic [31:0] lf = 32'h00012366;
  int err_total = 0;
  int tests_run = 0;
  int dn = 0;
  int k, par, guard, fec, shrt;

  // 4 ns clock
  initial forever #2 i_clk = ~i_clk;

  ubf_framer DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_grant_valid(i_grant_valid), .i_grant_bytes(i_grant_bytes),
    .o_grant_ready(o_grant_ready), .i_pkt_valid(i_pkt_valid), .i_pkt(i_pkt), .o_pkt_ready(o_pkt_ready),
    .o_out_valid(o_out_valid), .o_out(o_out), .i_out_ready(i_out_ready), .o_burst_done(o_burst_done));

  ubf_mac_model mac (.i_clk(i_clk), .i_grant_ready(o_grant_ready), .i_pkt_ready(o_pkt_ready),
    .i_slow(slow), .o_grant_valid(i_grant_valid), .o_grant_bytes(i_grant_bytes),
    .o_pkt_valid(i_pkt_valid), .o_pkt(i_pkt));

  // Fixed-seed shift register for data, lengths and stalls
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string what);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("BAD %0t %s seen %h want %h", $time, what, s, e);
    end
  endtask

  task automatic wrap_up();
    $display("Counts: %0d checks, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Register bus: one-cycle strobes, read data only in the following cycle
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    // Let an edge pass so a following write never reassigns the strobe in one step
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
    chk(o_rdata, e, "register");
  endtask

  // One codeword: info bytes (data, then zero pad), then parity slots
  task automatic cw(input int n, input int nd, input logic [7:0] d[$], input int pos);
    for (int i = 0; i < n + par; i++)
      exp_q.push_back(ubf_out_t'{(i < nd) ? d[pos + i] : 8'h00,
        (i < nd) ? KIND_DATA : (i < n) ? KIND_ZERO : KIND_PARITY, i == 0, i == n + par - 1});
  endtask

  // Expected output stream of one burst, worked out from grant and mode
  task automatic plan(input int len, input int g, input logic [7:0] d[$]);
    int rem, pos, n, nd;
    rem = g - guard;
    pos = 0;
    if (fec == 0) begin
      foreach (d[i]) exp_q.push_back(ubf_out_t'{d[i], KIND_RAW, 1'b0, 1'b0});
      return;
    end
    while (pos < len) begin
      nd = (len - pos < k) ? len - pos : k;
      n = (shrt != 0) ? ((nd < 16) ? 16 : nd) : k;
      cw(n, nd, d, pos);
      pos += nd;
      rem -= n + par;
    end
    while (k + par <= rem) begin
      cw(k, 0, d, 0);
      rem -= k + par;
    end
    if (shrt != 0 && rem >= 16 + par) cw(rem - par, 0, d, 0);
  endtask

  // Smallest grant that holds the data codewords
  function automatic int need(input int len);
    int r = len % k;
    if (fec == 0) return len;
    if (shrt == 0) return ((len + k - 1) / k) * (k + par);
    return (len / k) * (k + par) + ((r == 0) ? 0 : ((r < 16) ? 16 : r) + par);
  endfunction

  task automatic burst(input int len);
    logic [7:0] d[$];
    int g, d0, n;
    for (int i = 0; i < len; i++) d.push_back(rnd() & 32'hff);
    g = guard + need(len) + int'(rnd() % 40);
    plan(len, g, d);
    d0 = dn;
    slow = rnd() & 32'h1;
    mac.burst(g[GRANT_W-1:0], d);
    n = 0;
    while ((dn == d0 || exp_q.size() != 0) && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    chk(exp_q.size(), 0, "bytes still owed");
    repeat (2) @(posedge i_clk);
    chk(dn - d0, 1, "done pulses");
    chk(o_grant_ready, 1, "idle after burst");
  endtask

  // Output watcher with random back-pressure; a slow scrambler must not lose bytes
  always @(posedge i_clk) begin
    ubf_out_t e, s;
    i_out_ready <= (rnd() % 4) != 0;
    if (o_burst_done === 1'b1) dn++;
    if (o_out_valid === 1'b1 && i_out_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(o_out, 32'hffffffff, "unexpected byte");
      end else begin
        e = exp_q.pop_front();
        s = o_out;
        chk(s, e, "output byte");
      end
    end
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(REG_CTRL, 32'h00000001);
    rd(REG_CWK, 32'h00000010);
    rd(REG_PARITY, 32'h00000004);
    rd(REG_GUARD, 32'h00000002);
    rd(REG_STATUS, 32'h00000000);
    rd(4'h7, 32'h00000000);
    wr(REG_CWK, 32'h00000005);
    rd(REG_CWK, 32'h00000010);
    $display("Test registers done");
    // Modes: 0 fixed length, 1 shortened last, 2 no FEC
    for (int m = 0; m < 3; m++) begin
      fec = (m != 2);
      shrt = (m == 1);
      k = 20;
      par = 4 + m;
      guard = 3;
      wr(REG_CTRL, {30'h0, shrt[0], fec[0]});
      wr(REG_CWK, k);
      wr(REG_PARITY, par);
      wr(REG_GUARD, guard);
      rd(REG_CTRL, {30'h0, shrt[0], fec[0]});
      rd(REG_CWK, k);
      for (int b = 0; b < 6; b++) burst((b == 0) ? k : (b == 1) ? k + 1 : 1 + int'(rnd() % 60));
      $display("Test mode %0d done", m);
    end
    // Abort while idle keeps the framer idle; eighteen bursts counted
    wr(REG_CTRL, 32'h00000005);
    rd(REG_STATUS, 32'h00120000);
    rd(REG_CTRL, 32'h00000001);
    $display("Test status done");
    wrap_up();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (50000) @(posedge i_clk);
    err_total++;
    wrap_up();
  end
endmodule
